// ==== pwm_fan_led_controller.sv ====
// Purpose: One pulse-width controller instance with its register window
// Assumes: Bus, counter and tick enables all run on CLOCK
// Notes:   Fast source is every CLOCK edge; slow source is SLOW_TICK_ENABLE
//
// Behaviour
// - Any duty cycle over a wide frequency range
// - Output held high, held low, or toggling
// - Toggle levels last on-count plus one and off-count plus one ticks
// - Counter source is fast clock or slow tick
// - Register access handled on the bus clock
// - Four-bit pre-divider, settings zero to fifteen
// - Sleep clears counters and forces OFF state
// - Clock request is inverse of sleep input while enabled
// - Clock request low while controller disabled
// - System reset forces OFF and default registers
// - Power-on defaults 0000h, FFFFh, 0000h
// - Eight instances, windows 80h apart from F05800h
// - Pin tristates on power-on or watchdog event
// - Zero off-count full on; zero on-count full off unless off-count is also zero
// - Counts update after four bytes at OFF end, or at once if disabled or full on
// - Disable resets counters, output goes inactive
// - Invert bit polarity; bit 1 selects clock
`timescale 1ns/1ps
module pwm_fan_led_controller #(
  parameter int INSTANCE = 0
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [23:0] BUS_ADDR,
  input  wire logic        BUS_WRITE,
  input  wire logic        BUS_READ,
  input  wire logic [1:0]  BUS_BYTE_EN,
  input  wire logic [15:0] BUS_WDATA,
  output logic      [15:0] BUS_RDATA,
  input  wire logic        SLEEP_REQUEST_IN,
  input  wire logic        SLOW_TICK_ENABLE,
  input  wire logic        STANDBY_POWER_ON_RESET,
  input  wire logic        WATCHDOG_EVENT,
  input  wire logic        PIN_MUX_SELECT,
  output logic             PWM_PIN_OUT,
  output logic             PWM_PIN_OE,
  output logic             CLOCK_REQUEST
);

  // ************************************************************
  // Decode
  // ************************************************************
  localparam logic [23:0] MY_BASE =
    pwm_pkg::BASE_ADDR + 24'(INSTANCE) * pwm_pkg::INSTANCE_STEP;

  logic                    reg_reset;
  logic                    selected;
  logic [6:0]              offset;
  logic                    wr_high;
  logic                    wr_low;
  logic                    wr_cfg;
  logic [15:0]             high_period_count;
  logic [15:0]             low_period_count;
  logic [15:0]             hold_high;
  logic [15:0]             hold_low;
  logic [3:0]              hold_mask;
  logic [3:0]              wrote_bytes;
  logic                    enable;
  logic                    clk_sel;
  logic                    invert;
  logic [pwm_pkg::DIV_W-1:0] prediv;
  logic [15:0]             count;
  pwm_pkg::pwm_state_t     state;
  logic                    tick;
  logic                    source_tick;
  logic                    stop;
  logic                    reload_on;
  logic                    transfer;
  logic                    full_on;
  logic                    full_off;
  logic                    pin_blocked;

  assign reg_reset = !RST_N || STANDBY_POWER_ON_RESET;
  assign selected  = BUS_ADDR[23:pwm_pkg::WINDOW_BITS] == MY_BASE[23:pwm_pkg::WINDOW_BITS];
  assign offset    = BUS_ADDR[pwm_pkg::WINDOW_BITS-1:0];
  assign wr_high   = BUS_WRITE && selected && offset == pwm_pkg::OFF_HIGH_COUNT;
  assign wr_low    = BUS_WRITE && selected && offset == pwm_pkg::OFF_LOW_COUNT;
  assign wr_cfg    = BUS_WRITE && selected && offset == pwm_pkg::OFF_CONFIG;
  assign wrote_bytes = {{2{wr_low}} & BUS_BYTE_EN, {2{wr_high}} & BUS_BYTE_EN};

  // ************************************************************
  // Configuration register
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (reg_reset) begin
      enable  <= pwm_pkg::RST_CONFIG[pwm_pkg::CFG_ENABLE];
      clk_sel <= pwm_pkg::RST_CONFIG[pwm_pkg::CFG_CLK_SEL];
      invert  <= pwm_pkg::RST_CONFIG[pwm_pkg::CFG_INVERT];
      prediv  <= pwm_pkg::RST_CONFIG[pwm_pkg::CFG_DIV_MSB:pwm_pkg::CFG_DIV_LSB];
    end else if (wr_cfg && BUS_BYTE_EN[0]) begin
      enable  <= BUS_WDATA[pwm_pkg::CFG_ENABLE];
      clk_sel <= BUS_WDATA[pwm_pkg::CFG_CLK_SEL];
      invert  <= BUS_WDATA[pwm_pkg::CFG_INVERT];
      prediv  <= BUS_WDATA[pwm_pkg::CFG_DIV_MSB:pwm_pkg::CFG_DIV_LSB];
    end
  end

  // ************************************************************
  // Holding and active counts
  // ************************************************************
  // Only completed byte sets move over, so a half-written pair never glitches the wave
  assign reload_on = tick && state == pwm_pkg::ST_OFF && count == 16'h0000;
  assign transfer  = &hold_mask && (low_period_count == 16'h0000 || !enable || reload_on);

  always_ff @(posedge CLOCK) begin
    if (reg_reset) begin
      hold_high <= pwm_pkg::RST_HIGH_COUNT;
      hold_low  <= pwm_pkg::RST_LOW_COUNT;
      hold_mask <= 4'h0;
    end else begin
      if (wrote_bytes[0]) hold_high[7:0]  <= BUS_WDATA[7:0];
      if (wrote_bytes[1]) hold_high[15:8] <= BUS_WDATA[15:8];
      if (wrote_bytes[2]) hold_low[7:0]   <= BUS_WDATA[7:0];
      if (wrote_bytes[3]) hold_low[15:8]  <= BUS_WDATA[15:8];
      // A byte landing during the transfer stays marked for the next round
      hold_mask <= transfer ? wrote_bytes : (hold_mask | wrote_bytes);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (reg_reset) begin
      high_period_count <= pwm_pkg::RST_HIGH_COUNT;
      low_period_count  <= pwm_pkg::RST_LOW_COUNT;
    end else if (transfer) begin
      high_period_count <= hold_high;
      low_period_count  <= hold_low;
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      BUS_RDATA <= 16'h0000;
    end else if (BUS_READ && selected) begin
      unique case (offset)
        pwm_pkg::OFF_HIGH_COUNT: BUS_RDATA <= high_period_count;
        pwm_pkg::OFF_LOW_COUNT:  BUS_RDATA <= low_period_count;
        pwm_pkg::OFF_CONFIG:     BUS_RDATA <= {9'h000, prediv, invert, clk_sel, enable};
        default:                 BUS_RDATA <= 16'h0000;
      endcase
    end else begin
      BUS_RDATA <= 16'h0000;
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  assign stop        = reg_reset || !enable || SLEEP_REQUEST_IN;
  assign source_tick = clk_sel ? SLOW_TICK_ENABLE : 1'b1;

  pwm_prescaler u_prescaler (
    .CLOCK       (CLOCK),
    .RST_N       (RST_N),
    .clear       (stop),
    .source_tick (source_tick),
    .divide      (prediv),
    .tick        (tick)
  );

  always_ff @(posedge CLOCK) begin
    if (stop) begin
      count <= 16'h0000;
      state <= pwm_pkg::ST_OFF;
    end else if (tick) begin
      if (count == 16'h0000) begin
        unique case (state)
          pwm_pkg::ST_OFF: begin
            count <= high_period_count;
            state <= pwm_pkg::ST_ON;
          end
          pwm_pkg::ST_ON: begin
            count <= low_period_count;
            state <= pwm_pkg::ST_OFF;
          end
        endcase
      end else begin
        count <= count - 16'h0001;
      end
    end
  end

  // ************************************************************
  // Output and pin
  // ************************************************************
  assign full_on  = low_period_count == 16'h0000;
  assign full_off = high_period_count == 16'h0000;

  always_ff @(posedge CLOCK) begin
    if (stop) begin
      PWM_PIN_OUT <= invert;
    end else begin
      PWM_PIN_OUT <= invert ^ (full_on || (!full_off && state == pwm_pkg::ST_ON));
    end
  end

  // Blocked until the mux lets go, so a stale select cannot re-drive the fan
  always_ff @(posedge CLOCK) begin
    if (reg_reset || WATCHDOG_EVENT) begin
      pin_blocked <= 1'b1;
    end else if (!PIN_MUX_SELECT) begin
      pin_blocked <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (reg_reset || WATCHDOG_EVENT) begin
      PWM_PIN_OE <= 1'b0;
    end else begin
      PWM_PIN_OE <= PIN_MUX_SELECT && !pin_blocked;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      CLOCK_REQUEST <= 1'b0;
    end else begin
      CLOCK_REQUEST <= enable && !SLEEP_REQUEST_IN;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_zero_in_off;
    tick && state == pwm_pkg::ST_OFF && count == 16'h0000 && !stop;
  endsequence

  sequence s_watchdog_hit;
    WATCHDOG_EVENT ##1 !PWM_PIN_OE;
  endsequence

  property p_clock_request_on;
    @(posedge CLOCK) disable iff (!RST_N)
    (enable && !SLEEP_REQUEST_IN) |=> CLOCK_REQUEST;
  endproperty
  a_clock_request_on: assert property (p_clock_request_on) else $error("Clock request missing");

  property p_clock_request_off;
    @(posedge CLOCK) disable iff (!RST_N)
    !enable |=> !CLOCK_REQUEST;
  endproperty
  a_clock_request_off: assert property (p_clock_request_off) else $error("Clock request while off");

  property p_sleep_clears;
    @(posedge CLOCK) disable iff (!RST_N)
    SLEEP_REQUEST_IN |=> count == 16'h0000 && state == pwm_pkg::ST_OFF;
  endproperty
  a_sleep_clears: assert property (p_sleep_clears) else $error("Sleep left counter running");

  property p_disable_inactive;
    @(posedge CLOCK) disable iff (!RST_N)
    !enable |=> PWM_PIN_OUT == $past(invert);
  endproperty
  a_disable_inactive: assert property (p_disable_inactive) else $error("Disabled output active");

  property p_full_on;
    @(posedge CLOCK) disable iff (!RST_N)
    (!stop && full_on) |=> PWM_PIN_OUT == !$past(invert);
  endproperty
  a_full_on: assert property (p_full_on) else $error("Zero off-count not full on");

  property p_load_on;
    @(posedge CLOCK) disable iff (!RST_N)
    s_zero_in_off |=> state == pwm_pkg::ST_ON && count == $past(high_period_count);
  endproperty
  a_load_on: assert property (p_load_on) else $error("On-count not loaded");

  property p_transfer_full_on;
    @(posedge CLOCK) disable iff (!RST_N)
    (&hold_mask && full_on && !STANDBY_POWER_ON_RESET)
      |=> low_period_count == $past(hold_low) && hold_mask == $past(wrote_bytes);
  endproperty
  a_transfer_full_on: assert property (p_transfer_full_on) else $error("Held counts not moved");

  property p_watchdog_tristate;
    @(posedge CLOCK) disable iff (!RST_N)
    s_watchdog_hit |-> (PIN_MUX_SELECT [*1] ##1 !PWM_PIN_OE) or (!PIN_MUX_SELECT ##1 1'b1);
  endproperty
  a_watchdog_tristate: assert property (p_watchdog_tristate) else $error("Pin driven after watchdog");

  property p_reset_defaults;
    @(posedge CLOCK)
    !RST_N |=> high_period_count == pwm_pkg::RST_HIGH_COUNT
      && low_period_count == pwm_pkg::RST_LOW_COUNT && !enable;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("Reset defaults wrong");

endmodule

// ==== pwm_load_model.sv ====
// Purpose: Fan or LED load on the modulated pin, measures run lengths
// Assumes: External pull-up holds the pin high while it floats
// Notes:   Lengths are counted in CLOCK cycles
`timescale 1ns/1ps
module pwm_load_model (
  input  wire logic        clock,
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  output logic             level,
  output logic [15:0]      high_len,
  output logic [15:0]      low_len
);
  logic [15:0] run;
  logic        last;
  // A floating pin runs the fan at full speed, so overheating is avoided
  assign level = pin_oe ? pin_out : 1'b1;
  initial begin
    run = 16'h0000;
    last = 1'b1;
    high_len = 16'h0000;
    low_len = 16'h0000;
  end
  always @(posedge clock) begin
    last <= level;
    if (level === last) begin
      run <= run + 16'h0001;
    end else begin
      if (last) high_len <= run + 16'h0001;
      else low_len <= run + 16'h0001;
      run <= 16'h0000;
    end
  end
endmodule

// ==== pwm_pkg.sv ====
// Purpose: Shared constants for the fan and LED pulse-width controller
// Assumes: One clock; registers sit at byte offsets inside an 80h instance window
// Notes:   Offsets, field positions and reset values live here only
package pwm_pkg;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [23:0] BASE_ADDR      = 24'hF05800;
  localparam logic [23:0] INSTANCE_STEP  = 24'h000080;
  localparam int          INSTANCES      = 8;
  localparam int          WINDOW_BITS    = 7;
  localparam logic [6:0]  OFF_HIGH_COUNT = 7'h00;
  localparam logic [6:0]  OFF_LOW_COUNT  = 7'h04;
  localparam logic [6:0]  OFF_CONFIG     = 7'h08;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] RST_HIGH_COUNT = 16'h0000;
  localparam logic [15:0] RST_LOW_COUNT  = 16'hFFFF;
  localparam logic [15:0] RST_CONFIG     = 16'h0000;

  // ************************************************************
  // Configuration fields
  // ************************************************************
  localparam int CFG_ENABLE   = 0;
  localparam int CFG_CLK_SEL  = 1;
  localparam int CFG_INVERT   = 2;
  localparam int CFG_DIV_LSB  = 3;
  localparam int CFG_DIV_MSB  = 6;
  localparam int DIV_W        = 4;

  typedef enum logic [0:0] {
    ST_OFF = 1'b0,
    ST_ON  = 1'b1
  } pwm_state_t;

endpackage

// ==== pwm_prescaler.sv ====
// Purpose: Divides the selected counter clock source by setting plus one
// Assumes: Source arrives as a one-cycle enable on CLOCK
// Notes:   Tick output is registered, one cycle after the source pulse
`timescale 1ns/1ps
module pwm_prescaler (
  input  wire logic                     CLOCK,
  input  wire logic                     RST_N,
  input  wire logic                     clear,
  input  wire logic                     source_tick,
  input  wire logic [pwm_pkg::DIV_W-1:0] divide,
  output logic                          tick
);

  logic [pwm_pkg::DIV_W-1:0] count;

  // ************************************************************
  // Divider
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RST_N || clear) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (source_tick) begin
      if (count >= divide) begin
        count <= '0;
        tick  <= 1'b1;
      end else begin
        count <= count + 1'b1;
        tick  <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for one pulse-width controller instance
// Assumes: Instance 0; slow tick pulses every 5 cycles
// Notes:   Pin level is taken from the load model
`timescale 1ns/1ps
module tb_top;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        clock, rst_n, bus_write, bus_read, sleep_in, slow_tick;
  logic        por, wdt_ev, mux_sel, pin_out, pin_oe, clk_req, level;
  logic [23:0] bus_addr;
  logic [1:0]  bus_be;
  logic [15:0] bus_wdata, bus_rdata, high_len, low_len;
  int          bad_count, cmp_count, cycles, tick_div;

  pwm_fan_led_controller #(.INSTANCE(0)) DUT (
    .CLOCK(clock), .RST_N(rst_n), .BUS_ADDR(bus_addr), .BUS_WRITE(bus_write),
    .BUS_READ(bus_read), .BUS_BYTE_EN(bus_be), .BUS_WDATA(bus_wdata),
    .BUS_RDATA(bus_rdata), .SLEEP_REQUEST_IN(sleep_in), .SLOW_TICK_ENABLE(slow_tick),
    .STANDBY_POWER_ON_RESET(por), .WATCHDOG_EVENT(wdt_ev), .PIN_MUX_SELECT(mux_sel),
    .PWM_PIN_OUT(pin_out), .PWM_PIN_OE(pin_oe), .CLOCK_REQUEST(clk_req));

  pwm_load_model load (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .level(level), .high_len(high_len), .low_len(low_len));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] off, input logic [15:0] d);
    @(posedge clock);
    #1;
    bus_addr = pwm_pkg::BASE_ADDR + {17'h00000, off};
    bus_wdata = d;
    bus_write = 1'b1;
    @(posedge clock);
    #1;
    bus_write = 1'b0;
  endtask
  task automatic rd(input logic [23:0] off, input logic [15:0] exp);
    @(posedge clock);
    #1;
    bus_addr = pwm_pkg::BASE_ADDR + off;
    bus_read = 1'b1;
    @(posedge clock);
    #1;
    bus_read = 1'b0;
    chk(bus_rdata, exp);
  endtask
  task automatic wave(input int n, input logic [15:0] h, input logic [15:0] l);
    repeat (n) @(posedge clock);
    #1;
    chk(high_len, h);
    chk(low_len, l);
  endtask
  task automatic hold(input logic e);
    repeat (20) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      #1;
      chk({15'h0000, level}, {15'h0000, e});
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // ************************************************************
  // Clock, slow tick and timeout
  // ************************************************************
  always #20 clock = ~clock;
  always @(posedge clock) begin
    #1;
    tick_div = (tick_div == 4) ? 0 : tick_div + 1;
    slow_tick = (tick_div == 0);
  end
  // Longest path is about 980 cycles; the ceiling leaves wide margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    {clock, rst_n, bus_write, bus_read, sleep_in, slow_tick} = 6'h00;
    {por, wdt_ev, mux_sel} = 3'h0;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    tick_div = 0;
    bus_addr = 24'h000000;
    bus_be = 2'h3;
    bus_wdata = 16'h0000;
    repeat (4) @(posedge clock);
    #1;
    rst_n = 1'b1;
    rd(24'h000000, 16'h0000);
    rd(24'h000004, 16'hFFFF);
    rd(24'h000008, 16'h0000);
    rd(24'h00000C, 16'h0000);
    rd(24'h000084, 16'h0000);
    mux_sel = 1'b1;
    hold(1'b0);
    chk({15'h0000, pin_oe}, 16'h0001);
    wr(7'h00, 16'h0002);
    wr(7'h04, 16'h0003);
    rd(24'h000000, 16'h0002);
    wr(7'h08, 16'h0001);
    wave(100, 16'h0003, 16'h0004);
    chk({15'h0000, clk_req}, 16'h0001);
    wr(7'h08, 16'h0009);
    wave(100, 16'h0006, 16'h0008);
    wr(7'h08, 16'h000D);
    wave(100, 16'h0008, 16'h0006);
    wr(7'h08, 16'h0003);
    wave(200, 16'h000F, 16'h0014);
    wr(7'h08, 16'h0001);
    wr(7'h04, 16'h0005);
    wave(100, 16'h0003, 16'h0004);
    rd(24'h000004, 16'h0003);
    wr(7'h00, 16'h0001);
    wave(100, 16'h0002, 16'h0006);
    rd(24'h000004, 16'h0005);
    wr(7'h04, 16'h0000);
    wr(7'h00, 16'h0000);
    hold(1'b1);
    // Sleep taken while fully on, so a missed clear shows on the pin
    sleep_in = 1'b1;
    pause(2);
    chk({15'h0000, clk_req}, 16'h0000);
    hold(1'b0);
    sleep_in = 1'b0;
    pause(2);
    chk({15'h0000, clk_req}, 16'h0001);
    hold(1'b1);
    wr(7'h08, 16'h0005);
    hold(1'b0);
    wr(7'h08, 16'h0004);
    hold(1'b1);
    chk({15'h0000, clk_req}, 16'h0000);
    wr(7'h00, 16'h0000);
    wr(7'h04, 16'h0007);
    rd(24'h000004, 16'h0007);
    wr(7'h08, 16'h0001);
    hold(1'b0);
    wdt_ev = 1'b1;
    pause(1);
    wdt_ev = 1'b0;
    pause(1);
    chk({15'h0000, pin_oe}, 16'h0000);
    mux_sel = 1'b0;
    pause(2);
    mux_sel = 1'b1;
    pause(2);
    chk({15'h0000, pin_oe}, 16'h0001);
    por = 1'b1;
    pause(1);
    por = 1'b0;
    rd(24'h000004, 16'hFFFF);
    rd(24'h000008, 16'h0000);
    chk({15'h0000, pin_oe}, 16'h0000);
    wrap_up();
  end
endmodule
